//--- mlc_defs.vh
// Purpose: Constants for the modem line control settings block
// Assumes: 200 MHz system clock
// Notes:   Register indices are local selects on the settings port
`ifndef MLC_DEFS_VH
`define MLC_DEFS_VH
// Register selects
`define MLC_SEL_TRS     4'h0
`define MLC_SEL_RCD     4'h1
`define MLC_SEL_SPS     4'h2
`define MLC_SEL_RLD     4'h3
`define MLC_SEL_ATS     4'h4
`define MLC_SEL_FAST    4'h5
`define MLC_SEL_SLOW    4'h6
`define MLC_SEL_TONE    4'h7
`define MLC_SEL_TURN    4'h8
`define MLC_SEL_HOLD    4'h9
`define MLC_SEL_WAIT    4'hA
// Reset values
`define MLC_RST_TRS     8'h00
`define MLC_RST_RCD     8'h00
`define MLC_RST_SPS     8'h00
`define MLC_RST_RLD     8'h05
`define MLC_RST_ATS     8'h00
`define MLC_RST_FAST    8'h28
`define MLC_RST_SLOW    8'h00
`define MLC_RST_TONE    8'h21
`define MLC_RST_TURN    8'h14
`define MLC_RST_HOLD    8'h07
`define MLC_RST_WAIT    8'h3C
// Field positions
`define MLC_TRS_READY_LO 3
`define MLC_TRS_CARRIER  5
`define MLC_TRS_LONGSP   7
`define MLC_RCD_LEVEL_LO 4
`define MLC_RCD_RATIO    7
`define MLC_SPS_LOOP     0
`define MLC_SPS_RATE_LO  1
`define MLC_SPS_PAR_LO   4
`define MLC_ATS_TONE     6
// Timing: clock rate and tick periods
`define MLC_CLK_HZ       200000000
`define MLC_STEP_NS      12500000
`define MLC_STEP_CYC     (`MLC_CLK_HZ / 1000000 * (`MLC_STEP_NS / 1000))
`define MLC_HUND_CYC     (`MLC_CLK_HZ / 100)
`define MLC_SILENCE_S    2
`define MLC_TONE_MAX     8'h21
`endif

//--- mlc_line_control.v
// Purpose: Line control settings bank and answer/turnaround sequencing
// Assumes: Inputs synchronous to sys_clk; one register write per cycle
// Notes:   Tick periods are parameters so a simulation can shorten them
`timescale 1ns/10ps
`default_nettype none
`include "mlc_defs.vh"

module mlc_line_control #(
  parameter STEP_CYC = `MLC_STEP_CYC,
  parameter HUND_CYC = `MLC_HUND_CYC
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       sys_rst,
  // Settings port
  input  wire       cfg_wr,
  input  wire [3:0] cfg_sel,
  input  wire [7:0] cfg_wdata,
  output reg  [7:0] cfg_rdata,
  // Serial side
  input  wire       ready_line,
  input  wire       async_ready_sensitive,
  output reg        carrier_detect_out,
  output reg        ready_drop_to_command,
  output reg        ready_drop_hang_up,
  output reg        ready_drop_reset,
  output reg  [2:0] result_level,
  output reg        pulse_ratio_33_67,
  output reg  [2:0] serial_rate_code,
  output reg  [1:0] parity_mode,
  output reg        parity_changed,
  // Line side
  input  wire       connected,
  input  wire       reliable_link,
  input  wire       carrier_present,
  input  wire       disconnecting,
  input  wire       long_space_rx,
  input  wire       loopback_request,
  output reg        long_space_hang_up,
  output reg        loopback_accept,
  output reg        alt_answer_tone,
  // Answer and originate sequencing
  input  wire       answer_start,
  input  wire       originate_tone_seen,
  input  wire       rate_1200_up,
  input  wire       link_up,
  output reg  [2:0] answer_phase,
  output reg        answer_tone_on,
  output reg        originate_proceed,
  output reg        answer_hang_up,
  // Half-duplex carrier control
  input  wire       half_duplex,
  input  wire       tx_pending,
  output reg        hd_carrier_on
);

  // ****************************************************************
  // Settings registers
  // ****************************************************************
  reg [7:0] trs, rcd, sps, rld, ats, t_fast, t_slow, t_tone, t_turn, t_hold, t_wait;

  // Tone value above range is clipped on write
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trs <= `MLC_RST_TRS;
      rcd <= `MLC_RST_RCD;
      sps <= `MLC_RST_SPS;
      rld <= `MLC_RST_RLD;
      ats <= `MLC_RST_ATS;
      t_fast <= `MLC_RST_FAST;
      t_slow <= `MLC_RST_SLOW;
      t_tone <= `MLC_RST_TONE;
      t_turn <= `MLC_RST_TURN;
      t_hold <= `MLC_RST_HOLD;
      t_wait <= `MLC_RST_WAIT;
      parity_changed <= 1'b0;
    end else begin
      parity_changed <= 1'b0;
      if (cfg_wr) begin
        case (cfg_sel)
          `MLC_SEL_TRS:  trs <= cfg_wdata & 8'hB8;
          `MLC_SEL_RCD:  rcd <= cfg_wdata;
          `MLC_SEL_SPS: begin
            sps <= cfg_wdata;
            // Only parity field moves the format; widths stay put
            parity_changed <= (cfg_wdata[5:4] != sps[5:4]);
          end
          `MLC_SEL_RLD:  rld <= cfg_wdata;
          `MLC_SEL_ATS:  ats <= cfg_wdata & 8'h40;
          `MLC_SEL_FAST: t_fast <= cfg_wdata;
          `MLC_SEL_SLOW: t_slow <= cfg_wdata;
          `MLC_SEL_TONE: t_tone <= (cfg_wdata > `MLC_TONE_MAX) ? `MLC_TONE_MAX : cfg_wdata;
          `MLC_SEL_TURN: t_turn <= cfg_wdata;
          `MLC_SEL_HOLD: t_hold <= cfg_wdata;
          `MLC_SEL_WAIT: t_wait <= cfg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Readback, unmapped selects read the answer phase
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata <= 8'h00;
    end else begin
      case (cfg_sel)
        `MLC_SEL_TRS:  cfg_rdata <= trs;
        `MLC_SEL_RCD:  cfg_rdata <= rcd;
        `MLC_SEL_SPS:  cfg_rdata <= sps;
        `MLC_SEL_RLD:  cfg_rdata <= rld;
        `MLC_SEL_ATS:  cfg_rdata <= ats;
        `MLC_SEL_FAST: cfg_rdata <= t_fast;
        `MLC_SEL_SLOW: cfg_rdata <= t_slow;
        `MLC_SEL_TONE: cfg_rdata <= t_tone;
        `MLC_SEL_TURN: cfg_rdata <= t_turn;
        `MLC_SEL_HOLD: cfg_rdata <= t_hold;
        `MLC_SEL_WAIT: cfg_rdata <= t_wait;
        default:       cfg_rdata <= {5'h00, answer_phase};
      endcase
    end
  end

  // ****************************************************************
  // Tick dividers
  // ****************************************************************
  reg [31:0] step_cnt, hund_cnt;
  reg [3:0]  tenth_cnt;
  reg [3:0]  sec_cnt;
  reg        tick_step, tick_hund, tick_tenth, tick_sec;

  // Tenths and seconds cascade off hundredths so all stay aligned
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_cnt <= 32'h0;
      hund_cnt <= 32'h0;
      tenth_cnt <= 4'h0;
      sec_cnt <= 4'h0;
      tick_step <= 1'b0;
      tick_hund <= 1'b0;
      tick_tenth <= 1'b0;
      tick_sec <= 1'b0;
    end else begin
      tick_step <= (step_cnt == STEP_CYC - 1);
      step_cnt <= (step_cnt == STEP_CYC - 1) ? 32'h0 : step_cnt + 32'h1;
      tick_hund <= (hund_cnt == HUND_CYC - 1);
      hund_cnt <= (hund_cnt == HUND_CYC - 1) ? 32'h0 : hund_cnt + 32'h1;
      tick_tenth <= 1'b0;
      tick_sec <= 1'b0;
      if (tick_hund) begin
        tenth_cnt <= (tenth_cnt == 4'h9) ? 4'h0 : tenth_cnt + 4'h1;
        if (tenth_cnt == 4'h9) begin
          tick_tenth <= 1'b1;
          sec_cnt <= (sec_cnt == 4'h9) ? 4'h0 : sec_cnt + 4'h1;
          tick_sec <= (sec_cnt == 4'h9);
        end
      end
    end
  end

  // ****************************************************************
  // Ready line handling and static decodes
  // ****************************************************************
  reg       ready_q;
  reg [7:0] guard_cnt;
  reg       guard_done;
  reg [7:0] drop_cnt;
  reg       drop_pending;
  wire [1:0] ready_mode = trs[4:3];

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_q <= 1'b0;
      guard_cnt <= 8'h00;
      guard_done <= 1'b0;
      drop_cnt <= 8'h00;
      drop_pending <= 1'b0;
      ready_drop_to_command <= 1'b0;
      ready_drop_hang_up <= 1'b0;
      ready_drop_reset <= 1'b0;
    end else begin
      ready_q <= ready_line;
      ready_drop_to_command <= 1'b0;
      ready_drop_hang_up <= 1'b0;
      ready_drop_reset <= 1'b0;
      // Seconds guard after connect before ready is watched
      if (!connected) begin
        guard_cnt <= 8'h00;
        guard_done <= 1'b0;
      end else if (!guard_done) begin
        if (guard_cnt >= rld) guard_done <= 1'b1;
        else if (tick_sec) guard_cnt <= guard_cnt + 8'h01;
      end
      // Deglitch an on-to-off transition
      if (ready_line) begin
        drop_pending <= 1'b0;
      end else if (ready_q) begin
        drop_pending <= 1'b1;
        drop_cnt <= 8'h00;
      end else if (drop_pending) begin
        if (!(async_ready_sensitive && connected) || drop_cnt >= rld) begin
          drop_pending <= 1'b0;
          if (!connected || guard_done) begin
            case (ready_mode)
              2'd1: ready_drop_to_command <= 1'b1;
              2'd2: ready_drop_hang_up <= 1'b1;
              2'd3: ready_drop_reset <= 1'b1;
              default: ;
            endcase
          end
        end else if (tick_hund) begin
          drop_cnt <= drop_cnt + 8'h01;
        end
      end
    end
  end

  // Mode decodes registered for clean outputs
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      carrier_detect_out <= 1'b1;
      long_space_hang_up <= 1'b0;
      loopback_accept <= 1'b0;
      alt_answer_tone <= 1'b0;
      result_level <= 3'd0;
      pulse_ratio_33_67 <= 1'b0;
      serial_rate_code <= 3'd0;
      parity_mode <= 2'd0;
    end else begin
      carrier_detect_out <= !trs[`MLC_TRS_CARRIER] ||
                            (carrier_present && !disconnecting);
      long_space_hang_up <= trs[`MLC_TRS_LONGSP] && long_space_rx && connected;
      loopback_accept <= loopback_request && sps[`MLC_SPS_LOOP] && !reliable_link;
      alt_answer_tone <= ats[`MLC_ATS_TONE];
      // Codes 1 to 3 are not levels; treat as basic
      case (rcd[6:4])
        3'd4: result_level <= 3'd1;
        3'd5: result_level <= 3'd2;
        3'd6: result_level <= 3'd3;
        3'd7: result_level <= 3'd4;
        default: result_level <= 3'd0;
      endcase
      pulse_ratio_33_67 <= rcd[`MLC_RCD_RATIO];
      serial_rate_code <= sps[3:1];
      parity_mode <= sps[5:4];
    end
  end

  // ****************************************************************
  // Answer and originate sequencer
  // ****************************************************************
  localparam PH_IDLE = 3'd0;
  localparam PH_FAST = 3'd1;
  localparam PH_SLOW = 3'd2;
  localparam PH_SIL  = 3'd3;
  localparam PH_TONE = 3'd4;
  localparam PH_HALF = 3'd5;
  localparam PH_WAIT = 3'd6;
  localparam PH_ORIG = 3'd7;

  reg [7:0] ph_cnt;
  reg [7:0] wait_cnt;

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      answer_phase <= PH_IDLE;
      ph_cnt <= 8'h00;
      wait_cnt <= 8'h00;
      answer_tone_on <= 1'b0;
      originate_proceed <= 1'b0;
      answer_hang_up <= 1'b0;
    end else begin
      originate_proceed <= 1'b0;
      answer_hang_up <= 1'b0;
      if (link_up) begin
        answer_phase <= PH_IDLE;
        answer_tone_on <= 1'b0;
      end else begin
        case (answer_phase)
          PH_IDLE: begin
            ph_cnt <= 8'h00;
            wait_cnt <= 8'h00;
            if (originate_tone_seen) begin
              answer_phase <= PH_ORIG;
            end else if (answer_start) begin
              // Fast modes only at 1200 bps and up, else straight to PH_SIL, or to PH_HALF when t_tone is zero
              if (rate_1200_up) answer_phase <= PH_FAST;
              else if (t_tone == 8'h00) answer_phase <= PH_HALF;
              else answer_phase <= PH_SIL;
            end
          end
          PH_FAST: begin
            if (ph_cnt >= t_fast) begin
              answer_phase <= PH_SLOW;
              ph_cnt <= 8'h00;
            end else if (tick_tenth) ph_cnt <= ph_cnt + 8'h01;
          end
          PH_SLOW: begin
            if (t_slow == 8'h00) begin
              answer_phase <= PH_WAIT;
            end else if (ph_cnt >= t_slow) begin
              ph_cnt <= 8'h00;
              answer_phase <= (t_tone == 8'h00) ? PH_HALF : PH_SIL;
            end else if (tick_tenth) ph_cnt <= ph_cnt + 8'h01;
          end
          PH_SIL: begin
            if (ph_cnt >= `MLC_SILENCE_S) begin
              ph_cnt <= 8'h00;
              answer_phase <= PH_TONE;
              answer_tone_on <= 1'b1;
            end else if (tick_sec) ph_cnt <= ph_cnt + 8'h01;
          end
          PH_TONE: begin
            if (ph_cnt >= t_tone) begin
              answer_tone_on <= 1'b0;
              answer_phase <= PH_HALF;
            end else if (tick_tenth) ph_cnt <= ph_cnt + 8'h01;
          end
          PH_HALF, PH_WAIT: begin
            // Give up after the carrier wait time
            if (wait_cnt >= t_wait) begin
              answer_hang_up <= 1'b1;
              answer_phase <= PH_IDLE;
            end else if (tick_sec) wait_cnt <= wait_cnt + 8'h01;
          end
          PH_ORIG: begin
            if (ph_cnt >= t_tone) begin
              originate_proceed <= 1'b1;
              answer_phase <= PH_IDLE;
            end else if (tick_tenth) ph_cnt <= ph_cnt + 8'h01;
          end
          default: answer_phase <= PH_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Half-duplex carrier turnaround
  // ****************************************************************
  reg [7:0] hd_cnt;

  // Counter reused for hold (carrier on) and turnaround (carrier off)
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hd_carrier_on <= 1'b0;
      hd_cnt <= 8'h00;
    end else if (!half_duplex) begin
      hd_carrier_on <= 1'b0;
      hd_cnt <= 8'hFF;
    end else if (hd_carrier_on) begin
      if (tx_pending) hd_cnt <= 8'h00;
      else if (hd_cnt >= t_hold) begin
        hd_carrier_on <= 1'b0;
        hd_cnt <= 8'h00;
      end else if (tick_step) hd_cnt <= hd_cnt + 8'h01;
    end else begin
      if (hd_cnt >= t_turn) begin
        if (tx_pending) begin
          hd_carrier_on <= 1'b1;
          hd_cnt <= 8'h00;
        end
      end else if (tick_step) hd_cnt <= hd_cnt + 8'h01;
    end
  end

endmodule
`default_nettype wire

//--- mlc_far_end.sv
// Purpose: Remote modem and line model facing the line control block
// Assumes: Scenario controls come from the testbench at clock edges
// Notes:   Remote carrier stays off while our half-duplex carrier is up
`timescale 1ns/10ps
`default_nettype none
module mlc_far_end (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Scenario controls and our carrier
  input  wire logic want_carrier,
  input  wire logic want_loop,
  input  wire logic want_break,
  input  wire logic hd_carrier_on,
  // Line conditions seen by the device
  output var  logic carrier_present,
  output var  logic loopback_request,
  output var  logic long_space_rx
);
  // Registered line conditions; a real line never answers instantly
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      carrier_present  <= 1'b0;
      loopback_request <= 1'b0;
      long_space_rx    <= 1'b0;
    end else begin
      carrier_present  <= want_carrier && !hd_carrier_on;
      loopback_request <= want_loop;
      long_space_rx    <= want_break;
    end
  end
endmodule
`default_nettype wire

//--- mlc_line_control_chk.sv
// Purpose: Port assertions for the line control settings block
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Attached by the bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
`include "mlc_defs.vh"
module mlc_line_control_chk #(
  parameter STEP_CYC = 4,
  parameter HUND_CYC = 10
) (
  // Clock, reset and settings port
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       cfg_wr,
  input  wire logic [3:0] cfg_sel,
  input  wire logic [7:0] cfg_wdata,
  input  wire logic [7:0] cfg_rdata,
  // Observed outputs and levels
  input  wire logic       carrier_detect_out,
  input  wire logic       ready_drop_to_command,
  input  wire logic       ready_drop_hang_up,
  input  wire logic       ready_drop_reset,
  input  wire logic [2:0] result_level,
  input  wire logic       pulse_ratio_33_67,
  input  wire logic [2:0] serial_rate_code,
  input  wire logic [1:0] parity_mode,
  input  wire logic       parity_changed,
  input  wire logic       reliable_link,
  input  wire logic       loopback_accept,
  input  wire logic [2:0] answer_phase,
  input  wire logic       answer_tone_on,
  input  wire logic       half_duplex,
  input  wire logic       hd_carrier_on
);
  // Carrier report bit as last written, for the forced-on case
  reg  car_on;
  wire sps_wr;
  assign sps_wr = cfg_wr && cfg_sel == `MLC_SEL_SPS;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst)
      car_on <= 1'b0;
    else if (cfg_wr && cfg_sel == `MLC_SEL_TRS)
      car_on <= cfg_wdata[`MLC_TRS_CARRIER];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_ready_one_action: assert property ($onehot0({ready_drop_to_command,
    ready_drop_hang_up, ready_drop_reset})) else $error("two ready drop actions at once");
  a_carrier_forced_on: assert property (!car_on && !$past(car_on) |-> carrier_detect_out)
    else $error("carrier detect low while forced on");
  a_result_in_range: assert property (result_level <= 3'h4)
    else $error("result level above four");
  // Decodes are registered off the register, so they land two edges after the write
  a_ratio_follows_bit: assert property (cfg_wr && cfg_sel == `MLC_SEL_RCD |-> ##2
    pulse_ratio_33_67 == $past(cfg_wdata[7], 2)) else $error("dial ratio not updated");
  a_loop_reliable_off: assert property (reliable_link [*2] |-> !loopback_accept)
    else $error("loopback accepted on reliable link");
  a_rate_code_write: assert property (sps_wr |-> ##2
    serial_rate_code == $past(cfg_wdata[3:1], 2)) else $error("serial rate code wrong");
  a_parity_write: assert property (sps_wr |-> ##2
    parity_mode == $past(cfg_wdata[5:4], 2)) else $error("parity mode wrong");
  a_parity_change_pulse: assert property (sps_wr && cfg_wdata[5:4] != parity_mode |->
    ##[1:2] parity_changed) else $error("parity change not flagged");
  a_readback_delay: assert property (cfg_wr && cfg_sel == `MLC_SEL_RLD ##1 !cfg_wr &&
    cfg_sel == `MLC_SEL_RLD |=> cfg_rdata == $past(cfg_wdata, 2)) else $error("readback wrong");
  a_tone_in_phase: assert property (answer_tone_on |-> answer_phase == 3'h4 ||
    $past(answer_phase) == 3'h4) else $error("answer tone outside tone phase");
  a_silence_no_tone: assert property (answer_phase == 3'h3 [*2] |-> !answer_tone_on)
    else $error("tone during silence");
  a_hd_carrier_mode: assert property (!half_duplex [*2] |-> !hd_carrier_on)
    else $error("half duplex carrier outside half duplex");
  // Main scenarios reached
  c_half_try: cover property (answer_phase == 3'h5);
  c_parity_flag: cover property (parity_changed);
  c_loop_on: cover property (loopback_accept);
endmodule
bind mlc_line_control mlc_line_control_chk #(.STEP_CYC(STEP_CYC), .HUND_CYC(HUND_CYC)) u_chk (
  .sys_clk, .sys_rst, .cfg_wr, .cfg_sel, .cfg_wdata, .cfg_rdata, .carrier_detect_out,
  .ready_drop_to_command, .ready_drop_hang_up, .ready_drop_reset, .result_level,
  .pulse_ratio_33_67, .serial_rate_code, .parity_mode, .parity_changed, .reliable_link,
  .loopback_accept, .answer_phase, .answer_tone_on, .half_duplex, .hd_carrier_on);
`default_nettype wire

//--- testbench.sv
// Purpose: Self-checking bench for the line control settings block
// Assumes: Short ticks: 4 cycle step, 10 cycle hundredth, 1000 cycle second
// Notes:   Outputs are sampled at the edge, before that edge's updates land
`timescale 1ns/10ps
`default_nettype none
`include "mlc_defs.vh"
module testbench;
  // Reset values, select 0xA down to 0x0
  localparam [87:0] RST = 88'h3C_07_14_21_00_28_00_05_00_00_00;
  reg sys_clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, ready_line = 1'b1;
  reg async_ready_sensitive = 1'b0, connected = 1'b0, reliable_link = 1'b0;
  reg answer_start = 1'b0, originate_tone_seen = 1'b0, rate_1200_up = 1'b0;
  reg want_carrier = 1'b0, want_loop = 1'b0, want_break = 1'b0;
  reg disconnecting = 1'b0, link_up = 1'b0, half_duplex = 1'b0, tx_pending = 1'b0;
  reg [3:0] cfg_sel = 4'h0;
  reg [7:0] cfg_wdata = 8'h00, rv;
  reg [2:0] seen = 3'h0;
  reg clr_seen = 1'b0;
  integer miscompares = 0, compares = 0, cyc = 0, n_go = 0, n_hang = 0, i;
  wire [7:0] cfg_rdata;
  wire [2:0] result_level, serial_rate_code, answer_phase;
  wire [1:0] parity_mode;
  wire carrier_detect_out, ready_drop_to_command, ready_drop_hang_up, ready_drop_reset;
  wire pulse_ratio_33_67, parity_changed, long_space_hang_up, loopback_accept;
  wire alt_answer_tone, answer_tone_on, originate_proceed, answer_hang_up, hd_carrier_on;
  wire carrier_present, long_space_rx, loopback_request;
  always #2.5 sys_clk = ~sys_clk;
  mlc_line_control #(.STEP_CYC(4), .HUND_CYC(10)) u_mlc_line_control (.sys_clk, .sys_rst,
    .cfg_wr, .cfg_sel, .cfg_wdata, .cfg_rdata, .ready_line, .async_ready_sensitive,
    .carrier_detect_out, .ready_drop_to_command, .ready_drop_hang_up, .ready_drop_reset,
    .result_level, .pulse_ratio_33_67, .serial_rate_code, .parity_mode, .parity_changed,
    .connected, .reliable_link, .carrier_present, .disconnecting, .long_space_rx,
    .loopback_request, .long_space_hang_up, .loopback_accept, .alt_answer_tone,
    .answer_start, .originate_tone_seen, .rate_1200_up, .link_up, .answer_phase,
    .answer_tone_on, .originate_proceed, .answer_hang_up, .half_duplex, .tx_pending,
    .hd_carrier_on);
  mlc_far_end u_mlc_far_end (.sys_clk, .sys_rst, .want_carrier, .want_loop, .want_break,
    .hd_carrier_on, .carrier_present, .loopback_request, .long_space_rx);
  // Pulse monitors and hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    seen <= clr_seen ? 3'h0 : (seen | {ready_drop_reset, ready_drop_hang_up, ready_drop_to_command});
    n_go <= n_go + originate_proceed;
    n_hang <= n_hang + answer_hang_up;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      test_done;
    end
  end
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input [3:0] s, input [7:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_sel <= s;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask
  task rd(input [3:0] s, output [7:0] d);
    @(posedge sys_clk);
    cfg_sel <= s;
    tick(2);
    d = cfg_rdata;
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    compares = compares + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk1(input string nm, input e, input g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  // Write, read back, compare
  task rwc(input [3:0] s, input [7:0] d, input [7:0] e);
    wr(s, d);
    rd(s, rv);
    chk("readback", e, rv);
  endtask
  // Terminal ready off for n cycles, then the action seen
  task drop(input integer n, input [2:0] e);
    clr_seen <= 1'b1;
    tick(1);
    clr_seen <= 1'b0;
    ready_line <= 1'b0;
    tick(n);
    ready_line <= 1'b1;
    tick(40);
    chk("ready action", {5'h00, e}, {5'h00, seen});
  endtask
  task wph(input [2:0] p);
    integer k;
    k = 0;
    while (answer_phase !== p && k < 4000) begin
      @(posedge sys_clk);
      k = k + 1;
    end
    chk("phase", {5'h00, p}, {5'h00, answer_phase});
  endtask
  task pulse_start;
    answer_start <= 1'b1;
    tick(1);
    answer_start <= 1'b0;
  endtask
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ********************************
  // Main sequence
  // ********************************
  initial begin
    tick(5);
    sys_rst <= 1'b0;
    tick(2);
    for (i = 0; i < 11; i = i + 1) begin
      rd(i[3:0], rv);
      chk("reset value", RST[i*8 +: 8], rv);
    end
    rwc(`MLC_SEL_TRS, 8'hFF, 8'hB8);
    rwc(`MLC_SEL_ATS, 8'hFF, 8'h40);
    chk1("alt tone", 1'b1, alt_answer_tone);
    rwc(`MLC_SEL_TONE, 8'h30, 8'h21);
    rwc(4'hB, 8'hFF, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      wr(`MLC_SEL_SPS, {2'b00, i[1:0], i[2:0], 1'b0});
      tick(1);
      chk1("parity flag", i != 0, parity_changed);
      tick(2);
      chk("rate", {5'h00, i[2:0]}, {5'h00, serial_rate_code});
      chk("parity", {6'h00, i[1:0]}, {6'h00, parity_mode});
    end
    for (i = 0; i < 5; i = i + 1) begin
      wr(`MLC_SEL_RCD, {i[0], (i == 0) ? 3'h0 : 3'h3 + i[2:0], 4'h0});
      tick(3);
      chk("result", i[7:0], {5'h00, result_level});
      chk1("ratio", i[0], pulse_ratio_33_67);
    end
    wr(`MLC_SEL_SPS, 8'h01);
    want_loop <= 1'b1;
    tick(4);
    chk1("loop on", 1'b1, loopback_accept);
    reliable_link <= 1'b1;
    tick(4);
    chk1("loop reliable", 1'b0, loopback_accept);
    reliable_link <= 1'b0;
    wr(`MLC_SEL_SPS, 8'h00);
    tick(4);
    chk1("loop off", 1'b0, loopback_accept);
    wr(`MLC_SEL_TRS, 8'h00);
    tick(4);
    chk1("dcd forced", 1'b1, carrier_detect_out);
    wr(`MLC_SEL_TRS, 8'hA0);
    connected <= 1'b1;
    want_break <= 1'b1;
    tick(4);
    chk1("dcd follows", 1'b0, carrier_detect_out);
    chk1("long space", 1'b1, long_space_hang_up);
    want_break <= 1'b0;
    want_carrier <= 1'b1;
    connected <= 1'b0;
    tick(4);
    chk1("dcd follows", 1'b1, carrier_detect_out);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`MLC_SEL_TRS, {3'h0, i[1:0], 3'h0});
      drop(10, (4'h1 << i) >> 1);
    end
    rwc(`MLC_SEL_RLD, 8'h03, 8'h03);
    wr(`MLC_SEL_TRS, 8'h10);
    async_ready_sensitive <= 1'b1;
    connected <= 1'b1;
    drop(60, 3'h0);
    tick(3100);
    drop(5, 3'h0);
    drop(60, 3'h2);
    connected <= 1'b0;
    wr(`MLC_SEL_FAST, 8'h02);
    wr(`MLC_SEL_SLOW, 8'h01);
    wr(`MLC_SEL_TONE, 8'h03);
    wr(`MLC_SEL_WAIT, 8'h01);
    rate_1200_up <= 1'b1;
    pulse_start;
    wph(3'h1);
    wph(3'h2);
    wph(3'h3);
    chk1("silence", 1'b0, answer_tone_on);
    wph(3'h4);
    tick(3);
    chk1("tone", 1'b1, answer_tone_on);
    wph(3'h5);
    wph(3'h0);
    tick(1);
    chk("hang ups", 8'h01, n_hang[7:0]);
    wr(`MLC_SEL_SLOW, 8'h00);
    pulse_start;
    wph(3'h1);
    wph(3'h6);
    wph(3'h0);
    tick(1);
    chk("hang ups", 8'h02, n_hang[7:0]);
    originate_tone_seen <= 1'b1;
    tick(1);
    originate_tone_seen <= 1'b0;
    tick(150);
    chk("proceed", 8'h00, n_go[7:0]);
    tick(200);
    chk("proceed", 8'h01, n_go[7:0]);
    wr(`MLC_SEL_TONE, 8'h00);
    originate_tone_seen <= 1'b1;
    tick(1);
    originate_tone_seen <= 1'b0;
    tick(10);
    chk("proceed", 8'h02, n_go[7:0]);
    // Half duplex with default hold 7 and turnaround 20 steps of 4 cycles
    half_duplex <= 1'b1;
    tx_pending <= 1'b1;
    tick(4);
    chk1("hd on", 1'b1, hd_carrier_on);
    tx_pending <= 1'b0;
    tick(16);
    chk1("hd hold", 1'b1, hd_carrier_on);
    tick(24);
    chk1("hd drop", 1'b0, hd_carrier_on);
    tx_pending <= 1'b1;
    tick(40);
    chk1("hd turn", 1'b0, hd_carrier_on);
    tick(60);
    chk1("hd back", 1'b1, hd_carrier_on);
    test_done;
  end
endmodule
`default_nettype wire
